// ===== verilog/sacs_pkg.sv
package sacs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_CHEN     = 8'h04;
    localparam logic [7:0] OFF_SWCH     = 8'h08;
    localparam logic [7:0] OFF_RANGE_LO = 8'h0C;
    localparam logic [7:0] OFF_RANGE_HI = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1C;
    localparam logic [7:0] OFF_RANGEFL  = 8'h20;
    localparam logic [7:0] OFF_SAMPT0   = 8'h40;
    localparam logic [7:0] OFF_RESULT0  = 8'h60;

    // Control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_CONT   = 1;
    localparam int CTRL_SWMODE = 2;
    localparam int CTRL_START  = 3;
    localparam int CTRL_REF_LSB = 4;
    localparam int CTRL_LOWPWR = 6;

    // Interrupt status bits
    localparam int IRQ_RANGE = 0;
    localparam int IRQ_SCAN  = 1;
    localparam int IRQ_CONV  = 2;
    localparam int IRQ_W     = 3;

    // Reference choices
    localparam logic [1:0] REF_VDD      = 2'h0;
    localparam logic [1:0] REF_VDD_HALF = 2'h1;
    localparam logic [1:0] REF_BANDGAP  = 2'h2;
    localparam logic [1:0] REF_EXT_PIN  = 2'h3;

    // Converter timing
    localparam int    NUM_CH         = 8;
    localparam int    RES_W          = 12;
    localparam int    CONV_CLKS      = 18;
    localparam real   CLK_SYS_MHZ    = 50.0;
    localparam real   ADC_CLK_MAX_MHZ = 14.5;
    // Least divider so the converter clock stays at or under its limit
    localparam int    ADC_DIV        = int'($ceil(CLK_SYS_MHZ / ADC_CLK_MAX_MHZ));
    localparam logic [7:0] SAMPT_RST = 8'h04;

    typedef enum logic [1:0] {SACS_IDLE, SACS_SAMPLE, SACS_CONVERT} sacs_state_e;

endpackage : sacs_pkg

// ===== verilog/sacs_top.sv
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Converter clock <=14.5 MHz, 18 clocks per result
// - Reference select: VDD, VDD/2, bandgap, pin
// - Per-channel programmable sample time applied
// - Eight fixed channels, one selected per conversion
// - Scan steps enabled channels without software
// - No idle slots between channels
// - Channel switching by sequencer or firmware
// - One result register per input channel, none for the temperature sensor
// - Low/high window raises out-of-range interrupt
// - Range checked per result, immediately
// - Temperature sensor selectable as a channel
// - Unavailable in deep sleep and hibernate
module sacs_top #(
    parameter int NUM_CH = sacs_pkg::NUM_CH,
    parameter int RES_W  = sacs_pkg::RES_W
) (
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_n_i,
    // AHB-Lite slave
    input  wire logic                     hsel_i,
    input  wire logic [31:0]              haddr_i,
    input  wire logic [1:0]               htrans_i,
    input  wire logic                     hwrite_i,
    input  wire logic [2:0]               hsize_i,
    input  wire logic [31:0]              hwdata_i,
    input  wire logic                     hready_i,
    output logic [31:0]                   hrdata_o,
    output logic                          hreadyout_o,
    output logic                          hresp_o,
    // Power state from system
    input  wire logic                     deep_lowpwr_i,
    // Analog core
    output logic                          adc_clk_o,
    output logic                          sample_o,
    output logic                          convert_o,
    output logic [2:0]                    mux_sel_o,
    output logic                          temp_sel_o,
    output logic [1:0]                    ref_sel_o,
    input  wire logic                     adc_done_i,
    input  wire logic [RES_W-1:0]         adc_data_i,
    // Interrupt
    output logic                          irq_o
);
    import sacs_pkg::*;

    typedef struct packed {
        logic                       dphase;
        logic                       dwrite;
        logic [7:0]                 daddr;
        logic [31:0]                rdata;
        logic [6:0]                 ctrl;
        logic [NUM_CH-1:0]          chen;
        logic [3:0]                 swch;
        logic [RES_W-1:0]           lo;
        logic [RES_W-1:0]           hi;
        logic [IRQ_W-1:0]           stat;
        logic [IRQ_W-1:0]           mask;
        logic [NUM_CH-1:0]          rangefl;
        logic [NUM_CH-1:0][7:0]     sampt;
        logic [NUM_CH-1:0][RES_W-1:0] result;
        sacs_state_e                state;
        logic [3:0]                 ch;
        logic [7:0]                 divcnt;
        logic                       aclk;
        logic [7:0]                 cnt;
        logic                       running;
        logic                       irq;
        logic                       smp;
        logic                       cnv;
        logic                       tsel;
    } sacs_s;

    sacs_s cur_r;
    sacs_s cur_nxt;

    // First enabled channel at or after a start index
    function automatic logic [3:0] next_ch(input logic [NUM_CH-1:0] en,
                                           input logic [3:0] from);
        logic [3:0] r;
        r = 4'hF;
        for (int k = NUM_CH - 1; k >= 0; k--) begin
            if (en[k] && (k >= from)) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction : next_ch

    logic aclk_rise;
    logic active;
    logic [7:0] a;
    logic [IRQ_W-1:0] ev;
    logic [3:0] nx;

    always_comb begin
        cur_nxt   = cur_r;
        ev        = '0;
        nx        = 4'hF;
        a         = cur_r.daddr;
        // Low-power block gate from system and software
        active    = cur_r.ctrl[CTRL_ENABLE] && !deep_lowpwr_i && !cur_r.ctrl[CTRL_LOWPWR];

        // Converter clock divider
        aclk_rise = 1'b0;
        if (cur_r.divcnt >= 8'(ADC_DIV - 1)) begin
            cur_nxt.divcnt = '0;
            cur_nxt.aclk   = 1'b1;
            aclk_rise      = 1'b1;
        end else begin
            cur_nxt.divcnt = cur_r.divcnt + 8'h01;
            if (cur_r.divcnt == 8'(ADC_DIV / 2 - 1)) begin
                cur_nxt.aclk = 1'b0;
            end
        end

        // Sequencer
        case (cur_r.state)
            SACS_IDLE: begin
                if (active && cur_r.running && aclk_rise) begin
                    if (cur_r.ctrl[CTRL_SWMODE]) begin
                        cur_nxt.ch = cur_r.swch;
                    end else begin
                        cur_nxt.ch = next_ch(cur_r.chen, 4'h0);
                    end
                    if (!cur_r.ctrl[CTRL_SWMODE] && cur_r.chen == '0) begin
                        cur_nxt.running = 1'b0;
                    end else begin
                        cur_nxt.state = SACS_SAMPLE;
                        cur_nxt.cnt   = '0;
                    end
                end
            end
            SACS_SAMPLE: begin
                if (!active) begin
                    cur_nxt.state = SACS_IDLE;
                end else if (aclk_rise) begin
                    cur_nxt.cnt = cur_r.cnt + 8'h01;
                    // Per-channel aperture; temp sensor uses slot 0 timing
                    if (cur_r.cnt >= cur_r.sampt[cur_r.ch[2:0]]) begin
                        cur_nxt.state = SACS_CONVERT;
                        cur_nxt.cnt   = '0;
                    end
                end
            end
            SACS_CONVERT: begin
                if (!active) begin
                    cur_nxt.state = SACS_IDLE;
                end else if (aclk_rise && cur_r.cnt < 8'(CONV_CLKS)) begin
                    cur_nxt.cnt = cur_r.cnt + 8'h01;
                end else if (adc_done_i && cur_r.cnt >= 8'(CONV_CLKS)) begin
                    ev[IRQ_CONV] = 1'b1;
                    if (cur_r.ch < 4'(NUM_CH)) begin
                        cur_nxt.result[cur_r.ch[2:0]] = adc_data_i;
                    end
                    if (adc_data_i < cur_r.lo || adc_data_i > cur_r.hi) begin
                        ev[IRQ_RANGE] = 1'b1;
                        if (cur_r.ch < 4'(NUM_CH)) begin
                            cur_nxt.rangefl[cur_r.ch[2:0]] = 1'b1;
                        end
                    end
                    cur_nxt.cnt = '0;
                    if (cur_r.ctrl[CTRL_SWMODE]) begin
                        // Firmware-driven: one conversion per start, repeated while CONT is set
                        cur_nxt.state   = SACS_IDLE;
                        cur_nxt.running = cur_r.ctrl[CTRL_CONT];
                    end else begin
                        nx = next_ch(cur_r.chen, cur_r.ch + 4'h1);
                        if (nx == 4'hF) begin
                            ev[IRQ_SCAN] = 1'b1;
                            nx = next_ch(cur_r.chen, 4'h0);
                            cur_nxt.running = cur_r.ctrl[CTRL_CONT];
                        end
                        // Straight into next sample, no idle slot
                        if (cur_nxt.running && nx != 4'hF) begin
                            cur_nxt.ch    = nx;
                            cur_nxt.state = SACS_SAMPLE;
                        end else begin
                            cur_nxt.state   = SACS_IDLE;
                            cur_nxt.running = 1'b0;
                        end
                    end
                end
            end
            default: cur_nxt.state = SACS_IDLE;
        endcase

        // AHB-Lite data phase
        cur_nxt.dphase = 1'b0;
        if (cur_r.dphase && cur_r.dwrite) begin
            case (a)
                OFF_CTRL: begin
                    cur_nxt.ctrl = hwdata_i[6:0];
                    cur_nxt.ctrl[CTRL_START] = 1'b0;
                    if (hwdata_i[CTRL_START]) begin
                        cur_nxt.running = 1'b1;
                    end
                end
                OFF_CHEN:     cur_nxt.chen = hwdata_i[NUM_CH-1:0];
                OFF_SWCH:     cur_nxt.swch = hwdata_i[3:0];
                OFF_RANGE_LO: cur_nxt.lo   = hwdata_i[RES_W-1:0];
                OFF_RANGE_HI: cur_nxt.hi   = hwdata_i[RES_W-1:0];
                OFF_IRQ_MASK: cur_nxt.mask = hwdata_i[IRQ_W-1:0];
                // A flag set in the clearing cycle survives the clear
                OFF_RANGEFL:  cur_nxt.rangefl = (cur_r.rangefl & ~hwdata_i[NUM_CH-1:0])
                                              | (cur_nxt.rangefl & ~cur_r.rangefl);
                default: begin
                    if (a >= OFF_SAMPT0 && a < OFF_SAMPT0 + 8'(4 * NUM_CH)) begin
                        cur_nxt.sampt[3'(a[7:2] - OFF_SAMPT0[7:2])] = hwdata_i[7:0];
                    end
                end
            endcase
        end
        // Write-one clear; a same-cycle event wins
        if (cur_r.dphase && cur_r.dwrite && a == OFF_IRQ_STAT) begin
            cur_nxt.stat = cur_r.stat & ~hwdata_i[IRQ_W-1:0];
        end
        cur_nxt.stat = cur_nxt.stat | ev;
        cur_nxt.irq  = |(cur_nxt.stat & cur_nxt.mask);
        // Phase and channel outputs registered, no decode glitches at the core
        cur_nxt.smp  = (cur_nxt.state == SACS_SAMPLE);
        cur_nxt.cnv  = (cur_nxt.state == SACS_CONVERT);
        cur_nxt.tsel = cur_nxt.ch[3] && (cur_nxt.ch != 4'hF);

        if (hsel_i && hready_i && htrans_i[1]) begin
            cur_nxt.dphase = 1'b1;
            cur_nxt.dwrite = hwrite_i;
            cur_nxt.daddr  = {haddr_i[7:2], 2'b00};
            cur_nxt.rdata  = '0;
            if (!hwrite_i) begin
                case ({haddr_i[7:2], 2'b00})
                    OFF_CTRL:     cur_nxt.rdata = {25'h0, cur_r.ctrl};
                    OFF_CHEN:     cur_nxt.rdata = 32'(cur_r.chen);
                    OFF_SWCH:     cur_nxt.rdata = 32'(cur_r.swch);
                    OFF_RANGE_LO: cur_nxt.rdata = 32'(cur_r.lo);
                    OFF_RANGE_HI: cur_nxt.rdata = 32'(cur_r.hi);
                    OFF_IRQ_STAT: cur_nxt.rdata = 32'(cur_r.stat);
                    OFF_IRQ_MASK: cur_nxt.rdata = 32'(cur_r.mask);
                    OFF_STATUS:   cur_nxt.rdata = {24'h0, cur_r.ch, cur_r.running,
                                                   active, 2'(cur_r.state)};
                    OFF_RANGEFL:  cur_nxt.rdata = 32'(cur_r.rangefl);
                    default: begin
                        if (haddr_i[7:0] >= OFF_SAMPT0
                            && haddr_i[7:0] < OFF_SAMPT0 + 8'(4 * NUM_CH)) begin
                            cur_nxt.rdata = 32'(cur_r.sampt[3'(haddr_i[7:2]
                                                - OFF_SAMPT0[7:2])]);
                        end else if (haddr_i[7:0] >= OFF_RESULT0
                            && haddr_i[7:0] < OFF_RESULT0 + 8'(4 * NUM_CH)) begin
                            cur_nxt.rdata = 32'(cur_r.result[3'(haddr_i[7:2]
                                                - OFF_RESULT0[7:2])]);
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_r       <= '0;
            cur_r.hi    <= '1;
            cur_r.sampt <= {NUM_CH{SAMPT_RST}};
            cur_r.state <= SACS_IDLE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Outputs straight from state flops; hreadyout_o and hresp_o tied to constants
    assign hrdata_o    = cur_r.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign adc_clk_o   = cur_r.aclk;
    assign sample_o    = cur_r.smp;
    assign convert_o   = cur_r.cnv;
    assign mux_sel_o   = cur_r.ch[2:0];
    assign temp_sel_o  = cur_r.tsel;
    assign ref_sel_o   = cur_r.ctrl[CTRL_REF_LSB +: 2];
    assign irq_o       = cur_r.irq;

endmodule : sacs_top

// ===== test/sacs_properties.sv
`timescale 1ns/1ps
module sacs_properties (
    // Clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    // Bus and power inputs
    input wire logic       hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic       hwrite_i,
    input wire logic       hready_i,
    input wire logic       deep_lowpwr_i,
    // Converter and interrupt
    input wire logic       adc_clk_o,
    input wire logic       sample_o,
    input wire logic       convert_o,
    input wire logic [2:0] mux_sel_o,
    input wire logic       temp_sel_o,
    input wire logic       adc_done_i,
    input wire logic       irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic       wr_dp_r;
    logic [4:0] cnv_cnt_r;
    // Converter clock rises seen while converting, saturating
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_dp_r   <= 1'b0;
            cnv_cnt_r <= 5'h00;
        end else begin
            wr_dp_r <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
            if (!convert_o) cnv_cnt_r <= 5'h00;
            else if ($rose(adc_clk_o) && cnv_cnt_r != 5'h1F) cnv_cnt_r <= cnv_cnt_r + 5'h01;
        end
    end
    adc_rate_a:
        assert property ($rose(adc_clk_o) |=> (!$rose(adc_clk_o)) [*3])
        else $error("converter clock too fast");
    conv_len_a:
        assert property ($fell(convert_o) && !deep_lowpwr_i |-> cnv_cnt_r >= 5'h12)
        else $error("conversion shorter than 18 converter clocks");
    phase_excl_a: assert property (!(sample_o && convert_o))
        else $error("sample and convert together");
    samp_first_a: assert property ($rose(convert_o) |-> $past(sample_o))
        else $error("conversion without sampling");
    mux_hold_a:
        assert property (convert_o && $past(convert_o) |-> $stable({mux_sel_o, temp_sel_o}))
        else $error("channel changed in conversion");
    lowpwr_stop_a:
        assert property (deep_lowpwr_i [*3] |-> !sample_o && !convert_o)
        else $error("converter active in low power");
    irq_fall_a:
        assert property ($fell(irq_o) |-> $past(wr_dp_r) || $past(wr_dp_r, 2))
        else $error("interrupt dropped without a write");
    irq_rise_a:
        assert property ($rose(irq_o) |->
        $past(convert_o && adc_done_i) || $past(wr_dp_r) || $past(wr_dp_r, 2))
        else $error("interrupt rose without a cause");
    cover property ($fell(convert_o));
    cover property ($rose(irq_o));
    cover property (temp_sel_o && convert_o);
endmodule : sacs_properties

bind sacs_top sacs_properties chk_u (.clk_sys_i, .rst_n_i, .hsel_i, .htrans_i, .hwrite_i,
    .hready_i, .deep_lowpwr_i, .adc_clk_o, .sample_o, .convert_o, .mux_sel_o, .temp_sel_o,
    .adc_done_i, .irq_o);

// ===== test/sacs_adc_model.sv
`timescale 1ns/1ps
module sacs_adc_model (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Converter control
    input  wire logic        adc_clk_i,
    input  wire logic        convert_i,
    input  wire logic [2:0]  mux_sel_i,
    input  wire logic        temp_sel_i,
    input  wire logic [11:0] base_i,
    input  wire logic [3:0]  extra_i,
    // Result
    output logic             adc_done_o,
    output logic [11:0]      adc_data_o
);
    logic       clk_q;
    logic [5:0] cnt;
    logic       hit;
    // Result only after 18 converter clocks, plus extra for a slow core
    assign hit = convert_i && adc_clk_i && !clk_q && !adc_done_o &&
                 (cnt + 6'h01 >= 6'h12 + {2'h0, extra_i});
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_q      <= 1'b0;
            cnt        <= 6'h00;
            adc_done_o <= 1'b0;
            adc_data_o <= 12'h000;
        end else begin
            clk_q <= adc_clk_i;
            if (!convert_i) cnt <= 6'h00;
            else if (adc_clk_i && !clk_q) cnt <= cnt + 6'h01;
            adc_done_o <= hit || (adc_done_o && convert_i);
            // Data toggles when no result stands, so stale values never match
            if (hit) adc_data_o <= base_i + (temp_sel_i ? 12'h7AB : 12'h1F3 * {9'h000, mux_sel_i});
            else if (!(adc_done_o && convert_i)) adc_data_o <= ~adc_data_o;
        end
    end
endmodule : sacs_adc_model

// ===== test/sacs_top_tb.sv
`timescale 1ns/1ps
module sacs_top_tb;
    import sacs_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic        deep_lowpwr_i = 1'b0;
    logic        temp_seen = 1'b0;
    logic [1:0]  htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [11:0] base = 12'h000;
    logic [3:0]  extra = 4'h0;
    logic [31:0] hrdata_o;
    logic [31:0] rd;
    logic        hreadyout_o, hresp_o, adc_clk_o, sample_o, convert_o, temp_sel_o;
    logic        adc_done_i, irq_o;
    logic [2:0]  mux_sel_o;
    logic [1:0]  ref_sel_o;
    logic [11:0] adc_data_i;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    sacs_top dut_u (.clk_sys_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .deep_lowpwr_i, .adc_clk_o, .sample_o, .convert_o, .mux_sel_o, .temp_sel_o,
        .ref_sel_o, .adc_done_i, .adc_data_i, .irq_o);
    sacs_adc_model adc_u (.clk_sys_i, .rst_n_i, .adc_clk_i(adc_clk_o), .convert_i(convert_o),
        .mux_sel_i(mux_sel_o), .temp_sel_i(temp_sel_o), .base_i(base), .extra_i(extra),
        .adc_done_o(adc_done_i), .adc_data_o(adc_data_i));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_sys_i) begin
        cyc++;
        if (temp_sel_o && convert_o) temp_seen <= 1'b1;
        if (cyc == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One AHB-Lite single transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= {24'h0, a};
        hwrite_i <= w;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, hresp_o}, 32'h0);
    endtask : rdc

    task automatic wait_stat(input int b);
        for (int i = 0; i < 3000; i++) begin
            bus(1'b0, OFF_IRQ_STAT, 32'h0);
            if (rd[b] === 1'b1) return;
        end
        chk(32'h0, 32'h1);
    endtask : wait_stat

    function automatic logic [11:0] exp_val(input logic [3:0] ch);
        return base + (ch[3] ? 12'h7AB : 12'h1F3 * {9'h000, ch[2:0]});
    endfunction : exp_val

    initial begin
        logic [7:0]  chen;
        logic [7:0]  fl;
        logic [11:0] lo;
        logic [11:0] hi;
        logic [3:0]  sw;
        void'($urandom(70304));
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rdc(OFF_RANGE_HI, 32'hFFF);
        rdc(OFF_IRQ_MASK, 32'h0);
        rdc(OFF_SAMPT0 + 8'h1C, {24'h0, SAMPT_RST});
        rdc(8'h3C, 32'h0);
        $display("test reset done");
        for (int t = 0; t < 3; t++) begin
            chen = (t == 0) ? 8'hFF : 8'($urandom) | 8'h01;
            lo = 12'($urandom_range(1200));
            hi = lo + 12'($urandom_range(2000));
            base <= 12'($urandom);
            extra <= 4'($urandom_range(3));
            for (int c = 0; c < 8; c++) wr(OFF_SAMPT0 + 8'(4 * c), 32'($urandom_range(6)));
            wr(OFF_CHEN, {24'h0, chen});
            wr(OFF_RANGE_LO, {20'h0, lo});
            wr(OFF_RANGE_HI, {20'h0, hi});
            wr(OFF_IRQ_MASK, t[0] ? 32'h1 : 32'h3);
            wr(OFF_CTRL, {26'h0, 2'(t), 4'h9});
            wait_stat(IRQ_SCAN);
            chk({30'h0, ref_sel_o}, 32'(t));
            fl = 8'h00;
            for (int c = 0; c < 8; c++) begin
                fl[c] = chen[c] && (exp_val(4'(c)) < lo || exp_val(4'(c)) > hi);
                if (chen[c]) rdc(OFF_RESULT0 + 8'(4 * c), {20'h0, exp_val(4'(c))});
            end
            rdc(OFF_RANGEFL, {24'h0, fl});
            chk({31'h0, irq_o}, {31'h0, fl != 8'h00 || !t[0]});
            wr(OFF_RANGEFL, 32'hFF);
            wr(OFF_IRQ_STAT, 32'h7);
            rdc(OFF_IRQ_STAT, 32'h0);
            repeat (2) @(posedge clk_sys_i);
            chk({31'h0, irq_o}, 32'h0);
            $display("test scan %0d done", t);
        end
        for (int k = 0; k < 2; k++) begin
            sw = (k == 0) ? 4'h8 : 4'($urandom_range(7));
            wr(OFF_IRQ_STAT, 32'h7);
            wr(OFF_SWCH, {28'h0, sw});
            wr(OFF_CTRL, 32'h3D);
            wait_stat(IRQ_CONV);
            chk({30'h0, ref_sel_o}, 32'h3);
            if (k == 0) chk({31'h0, temp_seen}, 32'h1);
            else rdc(OFF_RESULT0 + {2'h0, sw[2:0], 2'h0}, {20'h0, exp_val(sw)});
        end
        $display("test firmware done");
        // Continuous scan must restart by itself, then stop in low power
        wr(OFF_IRQ_STAT, 32'h7);
        wr(OFF_CTRL, 32'hB);
        wait_stat(IRQ_SCAN);
        wr(OFF_IRQ_STAT, 32'h7);
        wait_stat(IRQ_SCAN);
        deep_lowpwr_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk({30'h0, sample_o, convert_o}, 32'h0);
        wr(OFF_CTRL, 32'h0);
        deep_lowpwr_i <= 1'b0;
        $display("test continuous done");
        report_and_stop();
    end
endmodule : sacs_top_tb
